// ### pkg/per_defs.vh
`ifndef PER_DEFS_VH
`define PER_DEFS_VH

// ==========================================================
// Register offsets.
`define PER_UNC_STAT_OFS   12'h104
`define PER_UNC_SEV_OFS    12'h10c
`define PER_COR_STAT_OFS   12'h110
`define PER_COR_MASK_OFS   12'h114
`define PER_CAPS_OFS       12'h118
`define PER_HLOG0_OFS      12'h11c
`define PER_HLOG1_OFS      12'h120
`define PER_HLOG2_OFS      12'h124
`define PER_HLOG3_OFS      12'h128
`define PER_IRQ_STAT_OFS   12'h130
`define PER_IRQ_MASK_OFS   12'h134

// ==========================================================
// Implemented bits and reset values.
`define PER_UNC_VALID      32'h001f_f011
`define PER_UNC_SEV_RST    32'h0006_2011
`define PER_COR_VALID      32'h0000_31c1
`define PER_COR_MASK_RST   32'h0000_2000
`define PER_ZERO32         32'h0000_0000

// ==========================================================
// Capability and control field positions.
`define PER_FEP_MSB        4
`define PER_FEP_LSB        0
`define PER_GEN_CAP_BIT    5
`define PER_GEN_EN_BIT     6
`define PER_CHK_CAP_BIT    7
`define PER_CHK_EN_BIT     8
`define PER_FEP_RST        5'h00

// ==========================================================
// Interrupt status layout.
`define PER_IRQ_COR_BIT    0
`define PER_IRQ_NF_BIT     1
`define PER_IRQ_FAT_BIT    2
`define PER_IRQ_W          3
`define PER_IRQ_RST        3'h0

`endif

// ### design/per_regs.v
`include "per_defs.vh"

module per_regs (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire         link_rst_i,
  input  wire         psel_i,
  input  wire         penable_i,
  input  wire         pwrite_i,
  input  wire [11:0]  paddr_i,
  input  wire [31:0]  pwdata_i,
  output reg          pready_o,
  output reg  [31:0]  prdata_o,
  output reg          pslverr_o,
  input  wire [31:0]  unc_evt_i,
  input  wire [31:0]  cor_evt_i,
  input  wire         hdr_valid_i,
  input  wire [127:0] hdr_i,
  output reg          msg_cor_o,
  output reg          msg_nonfatal_o,
  output reg          msg_fatal_o,
  output reg          ecrc_gen_en_o,
  output reg          ecrc_chk_en_o,
  output reg          irq_o
);

  // ==========================================================
  // State.
  reg  [31:0]  unc_stat_q;
  reg  [31:0]  unc_sev_q;
  reg  [31:0]  cor_stat_q;
  reg  [31:0]  cor_mask_q;
  reg  [4:0]   fep_q;
  reg          fep_lock_q;
  reg          gen_en_q;
  reg          chk_en_q;
  reg  [127:0] hlog_q;
  reg  [2:0]   irq_stat_q;
  reg  [2:0]   irq_mask_q;

  reg  [31:0]  unc_stat_d;
  reg  [31:0]  cor_stat_d;
  reg  [2:0]   irq_stat_d;
  reg  [31:0]  rdata;
  reg          hit;
  reg  [4:0]   first_pos;
  reg          first_hit;
  integer      i;

  wire         setup_acc = psel_i & penable_i & ~pready_o;
  wire         wr_done   = psel_i & penable_i & pready_o & pwrite_i;
  wire [31:0]  unc_evt   = unc_evt_i & `PER_UNC_VALID;
  wire [31:0]  cor_evt   = cor_evt_i & `PER_COR_VALID;
  wire [31:0]  cor_live  = cor_evt & ~cor_mask_q;
  wire         unc_any   = |unc_evt;
  wire         fat_any   = |(unc_evt & unc_sev_q);
  wire         nf_any    = |(unc_evt & ~unc_sev_q);
  wire         cor_any   = |cor_live;
  wire         fep_take  = unc_any & ~fep_lock_q;
  wire         log_take  = hdr_valid_i & ~fep_lock_q & (unc_any | cor_any);
  wire [31:0]  w1c       = pwdata_i;

  // ==========================================================
  // Lowest pending uncorrectable position.
  always @* begin
    first_pos = `PER_FEP_RST;
    first_hit = 1'b0;
    for (i = 31; i >= 0; i = i - 1) begin
      if (unc_evt[i]) begin
        first_pos = i[4:0];
        first_hit = 1'b1;
      end
    end
  end

  // ==========================================================
  // Status next values; an event in the clearing cycle wins.
  always @* begin
    unc_stat_d = unc_stat_q;
    cor_stat_d = cor_stat_q;
    irq_stat_d = irq_stat_q;
    if (wr_done && paddr_i == `PER_UNC_STAT_OFS) begin
      unc_stat_d = unc_stat_q & ~w1c;
    end
    if (wr_done && paddr_i == `PER_COR_STAT_OFS) begin
      cor_stat_d = cor_stat_q & ~w1c;
    end
    if (wr_done && paddr_i == `PER_IRQ_STAT_OFS) begin
      irq_stat_d = irq_stat_q & ~w1c[2:0];
    end
    unc_stat_d = (unc_stat_d | unc_evt) & `PER_UNC_VALID;
    cor_stat_d = (cor_stat_d | cor_evt) & `PER_COR_VALID;
    irq_stat_d[`PER_IRQ_COR_BIT] = irq_stat_d[`PER_IRQ_COR_BIT] | cor_any;
    irq_stat_d[`PER_IRQ_NF_BIT]  = irq_stat_d[`PER_IRQ_NF_BIT] | nf_any;
    irq_stat_d[`PER_IRQ_FAT_BIT] = irq_stat_d[`PER_IRQ_FAT_BIT] | fat_any;
  end

  // ==========================================================
  // Sticky registers, cleared only by the power reset.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      unc_stat_q <= `PER_ZERO32;
      unc_sev_q  <= `PER_UNC_SEV_RST;
      cor_stat_q <= `PER_ZERO32;
      cor_mask_q <= `PER_COR_MASK_RST;
      fep_q      <= `PER_FEP_RST;
      fep_lock_q <= 1'b0;
      gen_en_q   <= 1'b0;
      chk_en_q   <= 1'b0;
      hlog_q     <= {4{`PER_ZERO32}};
    end else begin
      unc_stat_q <= unc_stat_d;
      cor_stat_q <= cor_stat_d;
      if (wr_done && paddr_i == `PER_UNC_SEV_OFS) begin
        unc_sev_q <= pwdata_i & `PER_UNC_VALID;
      end
      if (wr_done && paddr_i == `PER_COR_MASK_OFS) begin
        cor_mask_q <= pwdata_i & `PER_COR_VALID;
      end
      if (wr_done && paddr_i == `PER_CAPS_OFS) begin
        gen_en_q <= pwdata_i[`PER_GEN_EN_BIT];
        chk_en_q <= pwdata_i[`PER_CHK_EN_BIT];
      end
      if (fep_take && first_hit) begin
        fep_q      <= first_pos;
        fep_lock_q <= 1'b1;
      end else if (fep_lock_q && !unc_stat_d[fep_q]) begin
        fep_lock_q <= 1'b0;
      end
      if (log_take) begin
        hlog_q <= hdr_i;
      end
    end
  end

  // ==========================================================
  // Messages and interrupt; cleared by either reset.
  always @(posedge clk_i) begin
    if (!rst_n_i || link_rst_i) begin
      msg_cor_o      <= 1'b0;
      msg_nonfatal_o <= 1'b0;
      msg_fatal_o    <= 1'b0;
      irq_stat_q     <= `PER_IRQ_RST;
      irq_mask_q     <= `PER_IRQ_RST;
      irq_o          <= 1'b0;
    end else begin
      msg_cor_o      <= cor_any;
      msg_nonfatal_o <= nf_any;
      msg_fatal_o    <= fat_any;
      irq_stat_q     <= irq_stat_d;
      if (wr_done && paddr_i == `PER_IRQ_MASK_OFS) begin
        irq_mask_q <= pwdata_i[2:0];
      end
      irq_o <= |(irq_stat_d & ~irq_mask_q);
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ecrc_gen_en_o <= 1'b0;
      ecrc_chk_en_o <= 1'b0;
    end else begin
      ecrc_gen_en_o <= gen_en_q;
      ecrc_chk_en_o <= chk_en_q;
    end
  end

  // ==========================================================
  // Read decode.
  always @* begin
    rdata = `PER_ZERO32;
    hit   = 1'b1;
    case (paddr_i)
      `PER_UNC_STAT_OFS: rdata = unc_stat_q;
      `PER_UNC_SEV_OFS:  rdata = unc_sev_q;
      `PER_COR_STAT_OFS: rdata = cor_stat_q;
      `PER_COR_MASK_OFS: rdata = cor_mask_q;
      `PER_CAPS_OFS: begin
        rdata[`PER_FEP_MSB:`PER_FEP_LSB] = fep_q;
        rdata[`PER_GEN_CAP_BIT] = 1'b1;
        rdata[`PER_GEN_EN_BIT]  = gen_en_q;
        rdata[`PER_CHK_CAP_BIT] = 1'b1;
        rdata[`PER_CHK_EN_BIT]  = chk_en_q;
      end
      `PER_HLOG0_OFS:    rdata = hlog_q[31:0];
      `PER_HLOG1_OFS:    rdata = hlog_q[63:32];
      `PER_HLOG2_OFS:    rdata = hlog_q[95:64];
      `PER_HLOG3_OFS:    rdata = hlog_q[127:96];
      `PER_IRQ_STAT_OFS: rdata = {29'h0000_0000, irq_stat_q};
      `PER_IRQ_MASK_OFS: rdata = {29'h0000_0000, irq_mask_q};
      default:           hit   = 1'b0;
    endcase
  end

  // ==========================================================
  // APB slave with one wait state.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= `PER_ZERO32;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup_acc;
      pslverr_o <= setup_acc & ~hit;
      if (setup_acc && !pwrite_i) begin
        prdata_o <= rdata;
      end
    end
  end

endmodule

// ### test/per_regs_props.sv
module per_regs_props (
  input logic        clk_i,
  input logic        rst_n_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [11:0] paddr_i,
  input logic        pready_o,
  input logic        pslverr_o,
  input logic [31:0] unc_evt_i,
  input logic [31:0] cor_evt_i,
  input logic        msg_cor_o,
  input logic        msg_nonfatal_o,
  input logic        msg_fatal_o,
  input logic        ecrc_gen_en_o,
  input logic        ecrc_chk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_ans;
    pready_o ##1 !pready_o;
  endsequence
  logic cw_w;
  assign cw_w = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 12'h118;
  chk_apb_answer: assert property (s_req |=> s_ans) else $error("late answer");
  chk_idle_quiet: assert property (!psel_i |-> !pready_o && !pslverr_o) else $error("idle answer");
  chk_err_addr: assert property (
    pslverr_o |-> pready_o && !(paddr_i inside {[12'h10c:12'h128]})) else $error("bad error");
  chk_cor_cause: assert property (msg_cor_o |-> $past(|cor_evt_i)) else $error("cor msg");
  chk_fat_cause: assert property (msg_fatal_o |-> $past(|unc_evt_i)) else $error("fat msg");
  chk_nf_cause: assert property (msg_nonfatal_o |-> $past(|unc_evt_i)) else $error("nf msg");
  chk_gen_follow: assert property (
    $changed(ecrc_gen_en_o) |-> $past(cw_w) || $past(cw_w, 2)) else $error("gen");
  chk_chk_follow: assert property (
    $changed(ecrc_chk_en_o) |-> $past(cw_w) || $past(cw_w, 2)) else $error("chk");
endmodule

bind per_regs per_regs_props chk_u (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pready_o, .pslverr_o, .unc_evt_i, .cor_evt_i, .msg_cor_o, .msg_nonfatal_o, .msg_fatal_o,
  .ecrc_gen_en_o, .ecrc_chk_en_o);

// ### test/per_rc_model.sv
module per_rc_model (
  input  logic clk_i,
  input  logic rst_n_i,
  input  logic msg_cor_i,
  input  logic msg_nonfatal_i,
  input  logic msg_fatal_i,
  output int   n_cor_o,
  output int   n_nf_o,
  output int   n_fat_o
);
  // ==========================================
  // Counts the error messages that arrive.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      {n_cor_o, n_nf_o, n_fat_o} <= '0;
    end else begin
      n_cor_o <= n_cor_o + int'(msg_cor_i);
      n_nf_o <= n_nf_o + int'(msg_nonfatal_i);
      n_fat_o <= n_fat_o + int'(msg_fatal_i);
    end
  end
endmodule

// ### test/per_regs_tb.sv
module per_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, link_rst_i, psel_i, penable_i, pwrite_i, hdr_valid_i, pready_o;
  logic pslverr_o, msg_cor_o, msg_nonfatal_o, msg_fatal_o, ecrc_gen_en_o, ecrc_chk_en_o, irq_o;
  logic [11:0]  paddr_i;
  logic [31:0]  pwdata_i, unc_evt_i, cor_evt_i, prdata_o, rdv;
  logic [127:0] hdr_i;
  logic         er;
  int           n_fail, tests_run, n_cor, n_nf, n_fat;
  int           b[6] = '{0, 6, 7, 8, 12, 13};
  localparam logic [127:0] HD = 128'hdddd_0004_cccc_0003_bbbb_0002_aaaa_0001;
  per_regs dut_u (.*);
  per_rc_model rc_u (.clk_i, .rst_n_i, .msg_cor_i(msg_cor_o), .msg_nonfatal_i(msg_nonfatal_o),
    .msg_fatal_i(msg_fatal_o), .n_cor_o(n_cor), .n_nf_o(n_nf), .n_fat_o(n_fat));
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      give_verdict();
    end
    rdv = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk(rdv, e);
  endtask
  task automatic evt(input logic [31:0] c, input logic [31:0] u, input logic h);
    cor_evt_i <= c;
    unc_evt_i <= u;
    hdr_valid_i <= h;
    @(posedge clk_i);
    {cor_evt_i, unc_evt_i, hdr_valid_i} <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  initial begin
    {psel_i, penable_i, pwrite_i, link_rst_i, hdr_valid_i, paddr_i} = '0;
    {pwdata_i, unc_evt_i, cor_evt_i} = '0;
    hdr_i = HD;
    rst_n_i = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1;
    rd(12'h10c, 32'h0006_2011);
    rd(12'h114, 32'h0000_2000);
    rd(12'h118, 32'h0000_00a0);
    evt(32'h0000_2000, 0, 1);
    rd(12'h110, 32'h0000_2000);
    chk(32'(n_cor), 0);
    rd(12'h11c, 0);
    apb(1, 12'h114, 32'hffff_ffff);
    rd(12'h114, 32'h0000_31c1);
    apb(1, 12'h114, 0);
    apb(1, 12'h110, 32'hffff_ffff);
    foreach (b[i]) begin
      evt(32'h1 << b[i], 0, 0);
      rd(12'h110, 32'h1 << b[i]);
      apb(1, 12'h110, 32'h1 << b[i]);
      rd(12'h110, 0);
      chk(32'(n_cor), 32'(i + 1));
    end
    evt(0, 32'h0000_0010, 1);
    evt(0, 32'h0000_1000, 0);
    rd(12'h104, 32'h0000_1010);
    rd(12'h118, 32'h0000_00a4);
    for (int i = 0; i < 4; i++) rd(12'h11c + 12'(4 * i), HD[32 * i +: 32]);
    chk(32'(n_fat * 2 + n_nf), 3);
    apb(1, 12'h118, 32'h0000_0140);
    @(negedge clk_i);
    chk(32'({ecrc_gen_en_o, ecrc_chk_en_o}), 3);
    @(posedge clk_i);
    link_rst_i <= 1;
    @(posedge clk_i);
    link_rst_i <= 0;
    @(posedge clk_i);
    chk(32'(irq_o), 0);
    rd(12'h118, 32'h0000_01e4);
    rd(12'h120, HD[63:32]);
    evt(32'h0000_0001, 0, 0);
    chk(32'(irq_o), 1);
    rd(12'h130, 32'h0000_0001);
    apb(1, 12'h134, 32'h0000_0001);
    @(negedge clk_i);
    chk(32'(irq_o), 0);
    @(posedge clk_i);
    apb(1, 12'h130, 32'h0000_0001);
    apb(1, 12'h134, 0);
    rd(12'h130, 0);
    apb(0, 12'h200, 0);
    chk(32'(er), 1);
    apb(1, 12'h10c, 32'hffff_ffff);
    rd(12'h10c, 32'h001f_f011);
    give_verdict();
  end
endmodule
